// >>> src/lsid_pkg.sv
// shared constants and types for the light screen indicator decoder
package lsid_pkg;

    // clock and timing, times in milliseconds
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
    localparam int unsigned FLASH_EIGHTH_MS = 125;  // one eighth of a lamp flash period
    localparam int unsigned SCAN_SHOW_MS    = 300;  // on or off half of one scan code flash
    localparam int unsigned RST_MIN_MS      = 250;
    localparam int unsigned RST_MAX_MS      = 2000;
    localparam int unsigned CNT_W           = 27;
    localparam logic [2:0]  SCAN_PHASES     = 3'h6; // three on/off pairs

    // register bus
    localparam int unsigned ADDR_W      = 8;
    localparam logic [7:0]  REG_CFG     = 8'h00;
    localparam logic [7:0]  REG_STAT    = 8'h04;
    localparam logic [7:0]  REG_ERR     = 8'h08;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // configuration register fields and reset value
    localparam int unsigned CFG_LATCH   = 0;
    localparam int unsigned CFG_REDRES  = 1;
    localparam int unsigned CFG_SCAN    = 2;
    localparam logic [2:0]  CFG_RESET   = 3'h0;     // trip, full resolution, scan code 1
    localparam logic [7:0]  SCAN_CODE1  = 8'h01;
    localparam logic [7:0]  SCAN_CODE2  = 8'h02;
    localparam int unsigned NZONE       = 8;

    typedef enum logic [1:0] {EM_POWERUP, EM_RUN, EM_TEST, EM_LOCKOUT} lsid_em_mode_t;
    typedef enum logic [1:0] {RXS_POWERUP, RXS_SCAN, RXS_LOCKOUT} lsid_rx_sense_t;
    typedef enum logic [2:0] {RS_POWERUP, RS_ALIGN, RS_RUN, RS_LATCHED, RS_LOCKOUT}
        lsid_rx_state_t;
    typedef enum logic [2:0] {DK_BLANK, DK_SCAN, DK_DASH, DK_LATCH, DK_COUNT, DK_ERROR}
        lsid_disp_kind_t;

    typedef struct packed {
        logic red;
        logic green;
    } lsid_lamp_t;

    typedef struct packed {
        lsid_disp_kind_t kind;
        logic            goalpost;
        logic [7:0]      value;
    } lsid_disp_t;

    typedef struct packed {
        logic [NZONE-1:0] zone_blocked;
        logic             beam1_blocked;
        logic [7:0]       blocked_count;
    } lsid_beams_t;

endpackage : lsid_pkg

// >>> src/lsid_flasher.sv
// free-running lamp flash pattern generator
`timescale 1ns/10ps
module lsid_flasher
    import lsid_pkg::*;
#(
    parameter int unsigned EIGHTH_CYC = FLASH_EIGHTH_MS * CYC_PER_MS
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // patterns
    output logic      flash,
    output logic      single,
    output logic      dbl
);

    logic [CNT_W-1:0] tick_q;
    logic [2:0]       ph_q;
    wire              tick_end = tick_q == CNT_W'(EIGHTH_CYC - 1);

    // eighth-period tick and phase; patterns are registered to stay glitch free
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tick_q <= '0;
            ph_q   <= 3'h0;
            flash  <= 1'b0;
            single <= 1'b0;
            dbl    <= 1'b0;
        end else begin
            tick_q <= tick_end ? '0 : tick_q + 1'b1;
            if (tick_end) ph_q <= ph_q + 1'b1;
            flash  <= !ph_q[2];                      // half on, half off
            single <= ph_q == 3'h0;                  // one short pulse per period
            dbl    <= ph_q == 3'h0 || ph_q == 3'h2;  // two short pulses
        end
    end

endmodule : lsid_flasher

// >>> src/lsid_decoder.sv
// light screen indicator decoder: emitter and receiver lamps, displays, safety outputs
// Contract
// RQ1: emitter status lamp: red flash power-up, green run, flashing green test, red flash fault
// RQ2: emitter display shows its error code during lockout
// RQ3: both displays show scan code at power-up and whenever it changes
// RQ4: receiver has eight zone lamps, each for one eighth of the beams
// RQ5: zone lamp green when clear, red when any beam in it blocked
// RQ6: receiver status green with outputs on, red off, flashing red lockout
// RQ7: reset lamp on in run, off in power-up, alignment and lockout
// RQ8: latch: reset lamp double-flash aligned clear, single-flash latched clear, outputs off
// RQ9: display shows dash for trip, L for latch, error code in lockout
// RQ10: power-up: status and zones single-flash red, reset off, outputs off, scan 3x
// RQ11: beam 1 blocked: only zone 1 red, other zones off
// RQ12: beam 1 clear, others blocked: display blocked count, outputs off
// RQ13: run all clear: outputs on, zones green, status green or flashing if reduced
// RQ14: lockout: outputs off, reset and zones off, status flashing red, error code
// RQ15: cascade stop: goalposts on display, outputs off, status red, reset lamp on
// RQ16: trip restores outputs when clear; latch waits for manual reset
// RQ17: reset switch held a quarter to two seconds then released; longer is ignored
// RQ18: all flash and scan display periods are clock-derived parameters
`timescale 1ns/10ps
module lsid_decoder
    import lsid_pkg::*;
#(
    parameter int unsigned EIGHTH_CYC  = FLASH_EIGHTH_MS * CYC_PER_MS,
    parameter int unsigned SCAN_CYC    = SCAN_SHOW_MS * CYC_PER_MS,
    parameter int unsigned RST_MIN_CYC = RST_MIN_MS * CYC_PER_MS,
    parameter int unsigned RST_MAX_CYC = RST_MAX_MS * CYC_PER_MS
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // emitter sensor state
    input  wire lsid_em_mode_t    em_mode,
    input  wire logic             em_health_warn,
    input  wire logic [7:0]       em_error_code,
    // receiver sensor state
    input  wire lsid_rx_sense_t   rx_sense,
    input  wire lsid_beams_t      rx_beams,
    input  wire logic [7:0]       rx_error_code,
    input  wire logic             cascade_stop_input,
    input  wire logic             reset_switch_closed,
    // indicators and outputs
    output lsid_lamp_t            em_status_lamp,
    output lsid_disp_t            em_display,
    output lsid_lamp_t            rx_status_lamp,
    output logic [NZONE-1:0]      rx_zone_red,
    output logic [NZONE-1:0]      rx_zone_green,
    output logic                  rx_reset_lamp,
    output lsid_disp_t            rx_display,
    output logic                  safety_outputs
);

    // mapped register check, shared by read and write paths
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        addr_ok = a == REG_CFG || a == REG_STAT || a == REG_ERR;
    endfunction : addr_ok

    // one zone lamp from the common receiver conditions
    function automatic lsid_lamp_t zone_lamp(input logic blk, input logic first,
                                             input logic pu, input logic lock,
                                             input logic b1, input logic sflash);
        zone_lamp.red   = pu ? sflash : lock ? 1'b0 : b1 ? first : blk;
        zone_lamp.green = !pu && !lock && !b1 && !blk;
    endfunction : zone_lamp

    // flash patterns
    logic fl_flash;
    logic fl_single;
    logic fl_dbl;

    lsid_flasher #(.EIGHTH_CYC(EIGHTH_CYC)) u_flash ( // RQ18
        .clk    (clk),
        .rst_n  (rst_n),
        .flash  (fl_flash),
        .single (fl_single),
        .dbl    (fl_dbl)
    );

    // ---------------- register bus ----------------
    logic [2:0]        cfg_q;
    logic              aw_hold_q;
    logic              w_hold_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [7:0]        w_byte_q;
    logic              w_lane_q;
    lsid_rx_state_t    st_q;
    lsid_rx_state_t    st_d;
    logic              scan_act_q;

    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire cfg_wr  = wr_fire && aw_addr_q == REG_CFG && w_lane_q;

    // status and error words read back
    wire [31:0] stat_word = {24'h0, st_q, scan_act_q, cascade_stop_input, rx_reset_lamp,
                             safety_outputs, rx_beams.beam1_blocked};
    wire [31:0] err_word  = {16'h0, em_error_code, rx_error_code};
    wire [31:0] rd_word   = s_axi_araddr == REG_CFG  ? {29'h0, cfg_q} :
                            s_axi_araddr == REG_STAT ? stat_word :
                            s_axi_araddr == REG_ERR  ? err_word : 32'h0;

    // address and data may arrive in either order; response once both are held
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            aw_addr_q    <= '0;
            w_byte_q     <= 8'h0;
            w_lane_q     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            cfg_q        <= CFG_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_byte_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_ok(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (cfg_wr) cfg_q <= w_byte_q[2:0];  // status and error words ignore writes
        end
    end

    // read data is registered; held until rready
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    wire latch_cfg = cfg_q[CFG_LATCH];
    wire redres    = cfg_q[CFG_REDRES];
    wire [7:0] scan_num = cfg_q[CFG_SCAN] ? SCAN_CODE2 : SCAN_CODE1;

    // ---------------- manual reset qualification ----------------
    logic [CNT_W-1:0] sw_cnt_q;
    logic             sw_q;
    logic             valid_reset_q;
    wire sw_open_edge = sw_q && !reset_switch_closed;
    wire sw_in_window = sw_cnt_q >= CNT_W'(RST_MIN_CYC) && sw_cnt_q <= CNT_W'(RST_MAX_CYC);
    wire sw_sat       = sw_cnt_q == CNT_W'(RST_MAX_CYC + 1);

    // closure length measured; a too-long hold saturates and is never accepted
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sw_q          <= 1'b0;
            sw_cnt_q      <= '0;
            valid_reset_q <= 1'b0;
        end else begin
            sw_q          <= reset_switch_closed;
            valid_reset_q <= sw_open_edge && sw_in_window; // RQ17
            if (!reset_switch_closed) sw_cnt_q <= '0;
            else if (!sw_sat) sw_cnt_q <= sw_cnt_q + 1'b1;
        end
    end

    // ---------------- scan code display ----------------
    logic [CNT_W-1:0] scan_cnt_q;
    logic [2:0]       scan_ph_q;
    logic             scan_prev_q;
    wire scan_chg  = scan_prev_q != cfg_q[CFG_SCAN];
    wire scan_tend = scan_cnt_q == CNT_W'(SCAN_CYC - 1);
    wire scan_vis  = scan_act_q && !scan_ph_q[0];

    // starts active out of reset, restarts on a change, three on/off pairs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scan_act_q  <= 1'b1;
            scan_cnt_q  <= '0;
            scan_ph_q   <= 3'h0;
            scan_prev_q <= CFG_RESET[CFG_SCAN];
        end else begin
            scan_prev_q <= cfg_q[CFG_SCAN];
            if (scan_chg) begin // RQ3
                scan_act_q <= 1'b1;
                scan_cnt_q <= '0;
                scan_ph_q  <= 3'h0;
            end else if (scan_act_q) begin
                scan_cnt_q <= scan_tend ? '0 : scan_cnt_q + 1'b1;
                if (scan_tend) begin
                    scan_ph_q <= scan_ph_q + 1'b1;
                    if (scan_ph_q == SCAN_PHASES - 3'h1) scan_act_q <= 1'b0; // RQ10
                end
            end
        end
    end

    // ---------------- receiver mode tracking ----------------
    wire all_clear = !rx_beams.beam1_blocked && rx_beams.blocked_count == 8'h0 &&
                     rx_beams.zone_blocked == '0;

    // latch config parks in latched state until a qualified reset with beams clear
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            RS_POWERUP: if (rx_sense == RXS_SCAN) st_d = RS_ALIGN;
            RS_ALIGN:   if (all_clear && (!latch_cfg || valid_reset_q)) st_d = RS_RUN; // RQ16
            RS_RUN:     if (latch_cfg && (!all_clear || cascade_stop_input))
                            st_d = RS_LATCHED; // RQ16
            RS_LATCHED: if (all_clear && !cascade_stop_input && valid_reset_q) st_d = RS_RUN;
            RS_LOCKOUT: if (valid_reset_q && rx_sense != RXS_LOCKOUT) st_d = RS_ALIGN;
            default:    st_d = RS_POWERUP;
        endcase
        if (rx_sense == RXS_LOCKOUT) st_d = RS_LOCKOUT;
        else if (rx_sense == RXS_POWERUP) st_d = RS_POWERUP;
    end

    // ---------------- receiver indicator decode ----------------
    wire in_pu   = st_q == RS_POWERUP;
    wire in_lock = st_q == RS_LOCKOUT;
    wire in_run  = st_q == RS_RUN;
    wire in_ltch = st_q == RS_LATCHED;
    wire in_aln  = st_q == RS_ALIGN;
    wire scanned = in_aln || in_run || in_ltch;
    wire b1_hold = rx_beams.beam1_blocked && scanned;
    wire aln_rdy = in_aln && latch_cfg && all_clear;
    wire safe_d  = in_run && all_clear && !cascade_stop_input; // RQ13 RQ12 RQ15 RQ14

    // green while on, flashing at reduced resolution; red otherwise
    wire rx_grn_d = safe_d && (!redres || fl_flash);                          // RQ6 RQ13
    wire rx_red_d = in_pu ? fl_single : in_lock ? fl_flash : !safe_d;         // RQ6 RQ10
    wire rst_lp_d = in_run ? 1'b1 :                                           // RQ7 RQ15
                    in_ltch ? ((all_clear && !cascade_stop_input) ? fl_single : 1'b1) : // RQ8
                    aln_rdy ? fl_dbl : 1'b0;                                  // RQ8 RQ7

    // zone lamps, one per eighth of the beam array
    lsid_lamp_t zone_d [NZONE];
    genvar gi;
    generate
        for (gi = 0; gi < NZONE; gi++) begin : g_zone
            assign zone_d[gi] = zone_lamp(rx_beams.zone_blocked[gi], gi == 0, in_pu, // RQ4
                                          in_lock, b1_hold, fl_single); // RQ5 RQ11 RQ10
        end
    endgenerate

    // receiver display: error first, then scan code, then count or config symbol
    wire show_cnt = !rx_beams.beam1_blocked && !all_clear && scanned;
    lsid_disp_kind_t rx_kind_d;
    assign rx_kind_d = in_lock ? DK_ERROR :                                  // RQ9 RQ14
                       (in_pu || scan_act_q) ? (scan_vis ? DK_SCAN : DK_BLANK) : // RQ3
                       aln_rdy ? DK_BLANK :
                       show_cnt ? DK_COUNT :                                 // RQ12
                       latch_cfg ? DK_LATCH : DK_DASH;                       // RQ9
    wire [7:0] rx_val_d = rx_kind_d == DK_ERROR ? rx_error_code :
                          rx_kind_d == DK_SCAN  ? scan_num :
                          rx_kind_d == DK_COUNT ? rx_beams.blocked_count : 8'h0;
    wire goal_d = cascade_stop_input && !in_pu && !in_lock; // RQ15

    // ---------------- emitter indicator decode ----------------
    wire em_fault = em_mode == EM_LOCKOUT || em_health_warn;
    wire em_red_d = em_fault ? fl_flash : em_mode == EM_POWERUP ? fl_single : 1'b0; // RQ1
    wire em_grn_d = !em_fault && (em_mode == EM_RUN || (em_mode == EM_TEST && fl_flash)); // RQ1
    lsid_disp_kind_t em_kind_d;
    assign em_kind_d = em_mode == EM_LOCKOUT ? DK_ERROR :                     // RQ2
                       (scan_act_q && scan_vis) ? DK_SCAN : DK_BLANK;        // RQ3
    wire [7:0] em_val_d = em_kind_d == DK_ERROR ? em_error_code :
                          em_kind_d == DK_SCAN  ? scan_num : 8'h0;

    // every indicator and the safety outputs come from flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q           <= RS_POWERUP;
            safety_outputs <= 1'b0;
            rx_status_lamp <= '0;
            rx_reset_lamp  <= 1'b0;
            rx_zone_red    <= '0;
            rx_zone_green  <= '0;
            rx_display     <= '0;
            em_status_lamp <= '0;
            em_display     <= '0;
        end else begin
            st_q           <= st_d;
            safety_outputs <= safe_d;
            rx_status_lamp <= '{red: rx_red_d, green: rx_grn_d};
            rx_reset_lamp  <= rst_lp_d;
            for (int i = 0; i < NZONE; i++) begin
                rx_zone_red[i]   <= zone_d[i].red;
                rx_zone_green[i] <= zone_d[i].green;
            end
            rx_display     <= '{kind: rx_kind_d, goalpost: goal_d, value: rx_val_d};
            em_status_lamp <= '{red: em_red_d, green: em_grn_d};
            em_display     <= '{kind: em_kind_d, goalpost: 1'b0, value: em_val_d};
        end
    end

    // ---------------- assertions ----------------
    property p_em_fault;
        @(posedge clk) disable iff (!rst_n)
        em_fault |=> em_status_lamp.red == $past(fl_flash) && !em_status_lamp.green;
    endproperty
    a_em_fault: assert property (p_em_fault) else $error("emitter fault lamp wrong"); // RQ1

    property p_em_err;
        @(posedge clk) disable iff (!rst_n)
        em_mode == EM_LOCKOUT |=> em_display.kind == DK_ERROR &&
                                  em_display.value == $past(em_error_code);
    endproperty
    a_em_err: assert property (p_em_err) else $error("emitter error code missing"); // RQ2

    property p_scan_chg;
        @(posedge clk) disable iff (!rst_n)
        scan_chg |=> scan_act_q ##1 rx_display.kind == DK_SCAN || in_lock;
    endproperty
    a_scan_chg: assert property (p_scan_chg) else $error("scan change not shown"); // RQ3

    property p_lock;
        @(posedge clk) disable iff (!rst_n)
        in_lock |=> !safety_outputs && !rx_reset_lamp && rx_zone_red == '0 &&
                    rx_zone_green == '0 && rx_display.kind == DK_ERROR;
    endproperty
    a_lock: assert property (p_lock) else $error("lockout indication wrong"); // RQ14

    property p_b1;
        @(posedge clk) disable iff (!rst_n)
        in_aln && rx_beams.beam1_blocked |=> rx_zone_red == 8'h01 && rx_zone_green == '0;
    endproperty
    a_b1: assert property (p_b1) else $error("beam 1 zone pattern wrong"); // RQ11

    sequence s_run_clear;
        in_run && all_clear && !cascade_stop_input;
    endsequence
    property p_run_on;
        @(posedge clk) disable iff (!rst_n)
        s_run_clear |=> safety_outputs && rx_zone_green == 8'hff && rx_reset_lamp;
    endproperty
    a_run_on: assert property (p_run_on) else $error("run clear outputs not on"); // RQ13

    property p_cascade;
        @(posedge clk) disable iff (!rst_n)
        cascade_stop_input && in_run |=> !safety_outputs && rx_display.goalpost &&
                                         rx_status_lamp.red && rx_reset_lamp;
    endproperty
    a_cascade: assert property (p_cascade) else $error("cascade stop indication wrong"); // RQ15

    property p_aln_dbl;
        @(posedge clk) disable iff (!rst_n)
        aln_rdy |=> rx_reset_lamp == $past(fl_dbl) && !safety_outputs;
    endproperty
    a_aln_dbl: assert property (p_aln_dbl) else $error("waiting reset not double flash"); // RQ8

    property p_cnt;
        @(posedge clk) disable iff (!rst_n)
        show_cnt && !in_pu && !scan_act_q |=> rx_display.kind == DK_COUNT &&
                                              !safety_outputs;
    endproperty
    a_cnt: assert property (p_cnt) else $error("blocked count not shown"); // RQ12

    property p_long_press;
        @(posedge clk) disable iff (!rst_n)
        sw_sat |=> !valid_reset_q;
    endproperty
    a_long_press: assert property (p_long_press) else $error("long press accepted"); // RQ17

endmodule : lsid_decoder

// >>> tb/lsid_op_panel.sv
// operator panel model: reset switch closed for the span asked with each press
`timescale 1ns/10ps
module lsid_op_panel (
    // clock
    input  wire logic       clk,
    // press request and its closure span in cycles
    input  wire logic       press,
    input  wire logic [7:0] hold,
    // switch
    output logic            reset_switch_closed
);
    logic [7:0] cnt_q = 8'h0;
    // a span past the accepted window must be ignored by the decoder
    always @(posedge clk) begin
        if (press && cnt_q == 8'h0) cnt_q <= hold;
        else if (cnt_q != 8'h0) cnt_q <= cnt_q - 8'h1;
    end
    assign reset_switch_closed = cnt_q != 8'h0;
endmodule : lsid_op_panel

// >>> tb/testbench.sv
// self-checking bench for the indicator decoder
`timescale 1ns/10ps
module testbench;
    import lsid_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, press = 1'b0, sw, so, rlamp;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0, csi = 1'b0;
    logic awr, wr_r, bv, arr, rv;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, em_err = 8'h3c, rx_err = 8'h5a;
    logic [31:0] wdata = 32'h0, rdata, got;
    logic [1:0] bresp, rresp, gresp;
    logic [NZONE-1:0] zr, zg;
    logic [16:0] rnd = 17'h10b37;
    lsid_em_mode_t em_mode = EM_POWERUP;
    lsid_rx_sense_t rx_sense = RXS_POWERUP;
    lsid_beams_t beams = '0;
    lsid_lamp_t em_lamp, rx_lamp;
    lsid_disp_t em_disp, rx_disp;
    int miscompares = 0, cmp_count = 0, n;
    logic hw = 1'b0;
    logic [3:0] wstrb = 4'hf;
    logic [7:0] hold = 8'h0a;
    always #12.5 clk = ~clk;
    lsid_decoder #(.EIGHTH_CYC(4), .SCAN_CYC(4), .RST_MIN_CYC(5), .RST_MAX_CYC(20)) uut (
        .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .em_mode(em_mode),
        .em_health_warn(hw), .em_error_code(em_err), .rx_sense(rx_sense), .rx_beams(beams),
        .rx_error_code(rx_err), .cascade_stop_input(csi), .reset_switch_closed(sw),
        .em_status_lamp(em_lamp), .em_display(em_disp), .rx_status_lamp(rx_lamp),
        .rx_zone_red(zr), .rx_zone_green(zg), .rx_reset_lamp(rlamp), .rx_display(rx_disp),
        .safety_outputs(so));
    lsid_op_panel panel (.clk(clk), .press(press), .hold(hold), .reset_switch_closed(sw));
    // 17-bit pseudo random sequence
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // ready is sampled mid-cycle, release lands on the taking edge
    task rd(input logic [7:0] a);
        logic r;
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin @(negedge clk); r = arr; @(posedge clk); end while (r !== 1'b1);
        arv <= 1'b0;
        do @(negedge clk); while (rv !== 1'b1);
        got = rdata;
        gresp = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask : rd
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic r;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin @(negedge clk); r = awr & wr_r; @(posedge clk); end while (r !== 1'b1);
        awv <= 1'b0;
        wv <= 1'b0;
        do @(negedge clk); while (bv !== 1'b1);
        gresp = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask : wr
    task settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle
    // ones over one flash period of 8 x 4 cycles: 0 emitter red, 1 reset lamp, 2 rx green
    task count_on(input int sel);
        n = 0;
        repeat (32) begin
            settle(1);
            n += sel == 0 ? em_lamp.red : sel == 1 ? rlamp : rx_lamp.green;
        end
    endtask : count_on
    // one press closed for h cycles, c cycles from the press (closure included) for the decoder to act
    task press_sw(input logic [7:0] h, input int c);
        @(posedge clk);
        hold <= h;
        press <= 1'b1;
        @(posedge clk);
        press <= 1'b0;
        settle(c);
    endtask : press_sw
    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict;
    end
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(REG_CFG);
        chk("cfg", 32'h0, got);
        chk("so_pu", 32'h0, so);
        chk("rlamp_pu", 32'h0, rlamp);
        rd(8'h0c);
        chk("resp", RESP_SLVERR, gresp);
        wr(REG_CFG, 32'h7, 4'he);
        chk("bresp", RESP_OKAY, gresp);
        rd(REG_CFG);
        chk("cfg_strb", 32'h0, got);
        rx_sense <= RXS_SCAN;
        em_mode <= EM_RUN;
        settle(40);
        chk("so_run", 32'h1, so);
        chk("zg_run", 32'hff, zg);
        chk("rlamp_run", 32'h1, rlamp);
        chk("em_lamp", 32'h1, em_lamp);
        @(posedge clk);
        hw <= 1'b1;
        settle(2);
        count_on(0);
        chk("em_warn", 32'h10, n);
        rnd = lfsr(rnd);
        @(posedge clk);
        hw <= 1'b0;
        beams <= {rnd[7:0] | 8'h02, 1'b0, rnd[15:8] | 8'h01};
        settle(3);
        chk("zr_blk", beams.zone_blocked, zr);
        chk("so_blk", 32'h0, so);
        chk("disp_blk", {DK_COUNT, beams.blocked_count}, {rx_disp.kind, rx_disp.value});
        @(posedge clk);
        beams <= '0;
        settle(3);
        chk("so_clr", 32'h1, so);
        wr(REG_CFG, 32'h4, 4'hf);
        settle(2);
        chk("disp_scan", {DK_SCAN, SCAN_CODE2}, {rx_disp.kind, rx_disp.value});
        rd(REG_CFG);
        chk("cfg_wr", 32'h4, got);
        @(posedge clk);
        rx_sense <= RXS_LOCKOUT;
        em_mode <= EM_LOCKOUT;
        settle(40);
        chk("so_lock", 32'h0, so);
        chk("zones_lock", 32'h0, {zr, zg, rlamp});
        chk("disp_lock", {DK_ERROR, rx_err}, {rx_disp.kind, rx_disp.value});
        chk("em_disp", {DK_ERROR, em_err}, {em_disp.kind, em_disp.value});
        wr(REG_CFG, 32'h7, 4'hf);
        rx_sense <= RXS_SCAN;
        press_sw(8'h1e, 40);
        chk("disp_long", DK_ERROR, rx_disp.kind);
        rnd = lfsr(rnd);
        @(posedge clk);
        beams <= {rnd[7:0], 1'b1, rnd[15:8]};
        press_sw(8'h0a, 20);
        chk("b1_zones", 32'h0100, {zr, zg});
        chk("so_b1", 32'h0, so);
        @(posedge clk);
        beams <= '0;
        settle(2);
        count_on(1);
        chk("dbl_flash", 32'h8, n);
        chk("so_wait", 32'h0, so);
        press_sw(8'h0a, 16);
        chk("so_rec", 32'h1, so);
        count_on(2);
        chk("grn_redres", 32'h10, n);
        @(posedge clk);
        csi <= 1'b1;
        settle(3);
        chk("so_csi", 32'h0, so);
        chk("csi_ind", 32'h7, {rx_disp.goalpost, rlamp, rx_lamp.red});
        @(posedge clk);
        csi <= 1'b0;
        settle(2);
        count_on(1);
        chk("sgl_flash", 32'h4, n);
        chk("so_latched", 32'h0, so);
        press_sw(8'h0a, 16);
        chk("so_unlatch", 32'h1, so);
        print_verdict;
    end
endmodule : testbench
